// ==== hdl/ism_pkg.sv ====
// Purpose: Shared constants and types of the I2C master status flag block.
// Assumes: Register indices are word indices; byte address is four times the index.
// Notes: Status and control words are eight bits wide in the low byte lane.
package ism_pkg;
  localparam logic [13:0] IDX_DATA = 14'hf50;
  localparam logic [13:0] IDX_STATUS = 14'hf51;
  localparam logic [13:0] IDX_CTRL = 14'hf52;
  localparam logic [13:0] IDX_IRQ_STAT = 14'hf53;
  localparam logic [13:0] IDX_IRQ_MASK = 14'hf54;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [2:0] IRQ_RST = 3'h0;
  localparam int IRQ_TX_BIT = 0;
  localparam int IRQ_RX_BIT = 1;
  localparam int IRQ_NACK_BIT = 2;
  localparam int IRQ_EVENTS = 3;
  localparam int SYNC_STAGES = 2;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef struct packed {
    logic tx_empty;
    logic rx_full;
    logic ack;
    logic ten_bit;
    logic rd;
    logic addr_phase;
    logic data_phase;
    logic nack_irq;
  } ism_status_s;

  typedef struct packed {
    logic enable;
    logic start;
    logic stop;
    logic birq;
    logic tx_irq_enable;
    logic nak;
    logic flush;
    logic filten;
  } ism_ctrl_s;

  typedef struct packed {
    logic wr_data;
    logic rd_data;
    logic rd_stat;
    logic wr_ctrl;
    logic wr_istat;
    logic wr_imask;
  } ism_access_s;

  typedef enum logic [3:0] {
    S_IDLE, S_START, S_BIT, S_STALL, S_ACK, S_AFTER, S_HOLD, S_STOP, S_STOP_RISE, S_STOP_END, S_RSTART
  } ism_state_e;
endpackage

// ==== hdl/ism_sync.sv ====
// Purpose: Two-stage synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to clk_i.
// Notes: Only the second stage is visible outside.
module ism_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '1;
      q_o <= '1;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

// ==== hdl/ism_irq.sv ====
// Purpose: Sticky interrupt status, mask and one level interrupt output.
// Assumes: Clear strobes come from write-one-to-clear bus writes.
// Notes: An event in the clearing cycle keeps its bit set.
module ism_irq #(
  parameter int WIDTH = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] ev_i,
  input wire logic [WIDTH-1:0] clr_i,
  input wire logic mask_we_i,
  input wire logic [WIDTH-1:0] mask_i,
  output logic [WIDTH-1:0] status_o,
  output logic [WIDTH-1:0] mask_o,
  output logic irq_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) status_o <= '0;
    else status_o <= (status_o & ~clr_i) | ev_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) mask_o <= '0;
    else if (mask_we_i) mask_o <= mask_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) irq_o <= 1'b0;
    else irq_o <= |(status_o & mask_o);
  end

  a_event_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    (ev_i != '0) |=> ((status_o & $past(ev_i)) == $past(ev_i)))
    else $error("event lost in sticky status");
  a_irq_masked: assert property (@(posedge clk_i) disable iff (rst_i)
    ((status_o & mask_o) == '0) |=> !irq_o)
    else $error("interrupt raised with no unmasked bit");
endmodule

// ==== hdl/ism_i2c_status.sv ====
// Purpose: I2C master byte engine with its status flags, control bits and a Wishbone slave.
// Assumes: SCL toggles from an outside generator; the engine stretches it low to pause.
// Notes: Pins are open-drain; the output enable pulls the line low.
//
// The Wishbone register port was chosen for this implementation.
module ism_i2c_status (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic dbg_access_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic irq_o,
  output logic tx_dma_req_o
);
  ism_pkg::ism_ctrl_s ctl_r;
  ism_pkg::ism_status_s st;
  ism_pkg::ism_access_s acc;
  ism_pkg::ism_state_e state_r;
  logic [7:0] data_r;
  logic [7:0] shift_r;
  logic [3:0] cnt_r;
  logic addr_r;
  logic rx_r;
  logic first_r;
  logic tx_empty_r;
  logic rx_full_r;
  logic ackf_r;
  logic ten_r;
  logic rd_r;
  logic nack_r;
  logic scl_prev_r;
  logic drive_lo_r;
  logic [1:0] pins_s;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic [2:0] ev;

  function automatic logic hit(input logic [15:0] adr, input logic [13:0] idx);
    return adr[15:2] == idx;
  endfunction

  ism_sync #(.WIDTH(ism_pkg::SYNC_STAGES)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({sda_i, scl_i}),
    .q_o(pins_s)
  );

  // Bus decode: a transfer commits at the edge where the master sees ack.
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire fire = wb_ack_o && wb_cyc_i && wb_stb_i;
  wire wr_lo = fire && wb_we_i && wb_sel_i[0];
  wire [7:0] wd = wb_dat_i[7:0];

  always_comb begin
    acc.wr_data = wr_lo && hit(wb_adr_i, ism_pkg::IDX_DATA);
    acc.rd_data = fire && !wb_we_i && hit(wb_adr_i, ism_pkg::IDX_DATA);
    acc.rd_stat = fire && !wb_we_i && hit(wb_adr_i, ism_pkg::IDX_STATUS);
    acc.wr_ctrl = wr_lo && hit(wb_adr_i, ism_pkg::IDX_CTRL);
    acc.wr_istat = wr_lo && hit(wb_adr_i, ism_pkg::IDX_IRQ_STAT);
    acc.wr_imask = wr_lo && hit(wb_adr_i, ism_pkg::IDX_IRQ_MASK);
  end

  // Engine decode.
  wire scl_s = pins_s[0];
  wire sda_s = pins_s[1];
  wire scl_rise = scl_s && !scl_prev_r;
  wire scl_fall = !scl_s && scl_prev_r;
  wire byte_end = cnt_r == ism_pkg::BITS_PER_BYTE;
  wire hold_req = ctl_r.start || ctl_r.stop;
  wire next_addr = ten_r && first_r && !rd_r;
  wire next_rx = rd_r && !next_addr;
  wire start_load = state_r == ism_pkg::S_START && scl_rise;
  wire after_fall = state_r == ism_pkg::S_AFTER && scl_fall;
  wire next_load = after_fall && !hold_req && !nack_r && !next_rx;
  wire load = start_load || next_load;
  wire ack_done = state_r == ism_pkg::S_ACK && scl_rise;
  wire ack_val = rx_r ? !ctl_r.nak : !sda_s;
  wire rx_done = ack_done && rx_r;
  wire nak_clr = rx_done && ctl_r.nak;
  wire nack_ev = ack_done && !ack_val && !hold_req;
  wire stop_done = state_r == ism_pkg::S_STOP_END;
  wire ten_clr = after_fall && first_r;
  wire ten_hit = data_r[7:3] == ism_pkg::TEN_BIT_PREFIX;
  wire dir_bit = data_r[0];
  wire stall_go = !next_rx && tx_empty_r && !hold_req;
  wire en_nxt = acc.wr_ctrl ? wd[7] : ctl_r.enable;
  wire sw_start_stop = acc.wr_ctrl && (wd[6] || wd[5]);

  // Control register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_r <= ism_pkg::CTRL_RST;
    end else begin
      ctl_r.enable <= en_nxt;
      if (acc.wr_ctrl) begin
        ctl_r.birq <= wd[4];
        ctl_r.tx_irq_enable <= wd[3];
        ctl_r.filten <= wd[0];
      end
      ctl_r.start <= en_nxt && ((ctl_r.start && !start_load) || (acc.wr_ctrl && wd[6]));
      ctl_r.stop <= en_nxt && ((ctl_r.stop && !stop_done) || (acc.wr_ctrl && wd[5]));
      ctl_r.nak <= en_nxt && ((ctl_r.nak && !nak_clr) || (acc.wr_ctrl && wd[2]));
      ctl_r.flush <= 1'b0;
    end
  end

  // Data register and transmit-empty.
  always_ff @(posedge clk_i) begin
    if (rst_i) data_r <= ism_pkg::DATA_RST;
    else if (acc.wr_data) data_r <= wd;
    else if (rx_done) data_r <= shift_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) tx_empty_r <= 1'b1;
    else if (acc.wr_data) tx_empty_r <= 1'b0;
    else if (load || (acc.wr_ctrl && wd[1])) tx_empty_r <= 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) rx_full_r <= 1'b0;
    else if (rx_done && ctl_r.enable) rx_full_r <= 1'b1;
    else if (acc.rd_data && !dbg_access_i) rx_full_r <= 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) ackf_r <= 1'b0;
    else if (!ctl_r.enable) ackf_r <= 1'b0;
    else if (ack_done) ackf_r <= ack_val;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !ctl_r.enable) ten_r <= 1'b0;
    else if (start_load) ten_r <= ten_hit;
    else if (ten_clr) ten_r <= 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) rd_r <= 1'b0;
    else if (start_load) rd_r <= dir_bit;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) nack_r <= 1'b0;
    else if (nack_ev) nack_r <= 1'b1;
    else if (!ctl_r.enable || stop_done || sw_start_stop) nack_r <= 1'b0;
  end

  // Status word; writes to it are not decoded and have no effect.
  always_comb begin
    st.tx_empty = tx_empty_r;
    st.rx_full = rx_full_r;
    st.ack = ackf_r;
    st.ten_bit = ten_r;
    st.rd = rd_r;
    st.addr_phase = state_r == ism_pkg::S_BIT && addr_r;
    st.data_phase = state_r == ism_pkg::S_BIT && !addr_r;
    st.nack_irq = nack_r;
  end

  wire tx_hush = (st.data_phase && rx_r) || (st.addr_phase && rd_r);

  always_comb begin
    ev = 3'h0;
    ev[ism_pkg::IRQ_TX_BIT] = ctl_r.enable && tx_empty_r && ctl_r.tx_irq_enable && !tx_hush;
    ev[ism_pkg::IRQ_RX_BIT] = rx_full_r;
    ev[ism_pkg::IRQ_NACK_BIT] = nack_r;
  end

  ism_irq #(.WIDTH(ism_pkg::IRQ_EVENTS)) u_irq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ev_i(ev),
    .clr_i(acc.wr_istat ? wd[2:0] : 3'h0),
    .mask_we_i(acc.wr_imask),
    .mask_i(wd[2:0]),
    .status_o(irq_stat),
    .mask_o(irq_mask),
    .irq_o(irq_o)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) tx_dma_req_o <= 1'b0;
    else tx_dma_req_o <= ctl_r.enable && tx_empty_r && ctl_r.tx_irq_enable;
  end

  // Bus answer: ack one cycle after the request, read data with it.
  always_ff @(posedge clk_i) begin
    if (rst_i) wb_ack_o <= 1'b0;
    else wb_ack_o <= req;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (req) begin
      wb_dat_o <= 32'h0;
      if (hit(wb_adr_i, ism_pkg::IDX_DATA)) wb_dat_o[7:0] <= data_r;
      else if (hit(wb_adr_i, ism_pkg::IDX_STATUS)) wb_dat_o[7:0] <= st;
      else if (hit(wb_adr_i, ism_pkg::IDX_CTRL)) wb_dat_o[7:0] <= {ctl_r[7:2], 1'b0, ctl_r.filten};
      else if (hit(wb_adr_i, ism_pkg::IDX_IRQ_STAT)) wb_dat_o[2:0] <= irq_stat;
      else if (hit(wb_adr_i, ism_pkg::IDX_IRQ_MASK)) wb_dat_o[2:0] <= irq_mask;
    end
  end

  // Pin drive: only low is ever driven.
  always_ff @(posedge clk_i) begin
    drive_lo_r <= 1'b0;
  end
  assign scl_o = drive_lo_r;
  assign sda_o = drive_lo_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) scl_prev_r <= 1'b1;
    else scl_prev_r <= scl_s;
  end

  // Byte engine.
  always_ff @(posedge clk_i) begin
    if (rst_i || !ctl_r.enable) begin
      state_r <= ism_pkg::S_IDLE;
      sda_oe_o <= 1'b0;
      scl_oe_o <= 1'b0;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      addr_r <= 1'b0;
      rx_r <= 1'b0;
      first_r <= 1'b0;
    end else begin
      case (state_r)
        ism_pkg::S_IDLE: begin
          if (ctl_r.stop) state_r <= ism_pkg::S_STOP;
          else if (ctl_r.start && !tx_empty_r) state_r <= ism_pkg::S_START;
        end
        ism_pkg::S_START: begin
          if (scl_rise) begin
            sda_oe_o <= 1'b1;
            shift_r <= data_r;
            cnt_r <= 4'h0;
            addr_r <= 1'b1;
            rx_r <= 1'b0;
            first_r <= 1'b1;
            state_r <= ism_pkg::S_BIT;
          end
        end
        ism_pkg::S_BIT: begin
          if (scl_fall && byte_end) begin
            if (stall_go) begin
              scl_oe_o <= 1'b1;
              sda_oe_o <= 1'b0;
              state_r <= ism_pkg::S_STALL;
            end else begin
              sda_oe_o <= rx_r && !ctl_r.nak;
              state_r <= ism_pkg::S_ACK;
            end
          end else if (scl_fall) begin
            sda_oe_o <= !rx_r && !shift_r[7];
          end else if (scl_rise && !byte_end) begin
            shift_r <= {shift_r[6:0], sda_s};
            cnt_r <= cnt_r + 4'h1;
          end
        end
        ism_pkg::S_STALL: begin
          if (!tx_empty_r || hold_req) begin
            scl_oe_o <= 1'b0;
            state_r <= ism_pkg::S_ACK;
          end
        end
        ism_pkg::S_ACK: begin
          if (scl_rise) state_r <= ism_pkg::S_AFTER;
        end
        ism_pkg::S_AFTER: begin
          if (scl_fall) begin
            sda_oe_o <= 1'b0;
            if (ctl_r.stop) begin
              sda_oe_o <= 1'b1;
              state_r <= ism_pkg::S_STOP_RISE;
            end else if (ctl_r.start) begin
              state_r <= ism_pkg::S_RSTART;
            end else if (nack_r) begin
              scl_oe_o <= 1'b1;
              state_r <= ism_pkg::S_HOLD;
            end else begin
              addr_r <= next_addr;
              rx_r <= next_rx;
              first_r <= 1'b0;
              cnt_r <= 4'h0;
              state_r <= ism_pkg::S_BIT;
              if (!next_rx) begin
                shift_r <= data_r;
                sda_oe_o <= !data_r[7];
              end
            end
          end
        end
        ism_pkg::S_HOLD: begin
          if (ctl_r.stop) begin
            scl_oe_o <= 1'b0;
            sda_oe_o <= 1'b1;
            state_r <= ism_pkg::S_STOP_RISE;
          end else if (ctl_r.start) begin
            scl_oe_o <= 1'b0;
            state_r <= ism_pkg::S_RSTART;
          end
        end
        ism_pkg::S_STOP: begin
          if (scl_fall) begin
            sda_oe_o <= 1'b1;
            state_r <= ism_pkg::S_STOP_RISE;
          end
        end
        ism_pkg::S_STOP_RISE: begin
          if (scl_rise) begin
            sda_oe_o <= 1'b0;
            state_r <= ism_pkg::S_STOP_END;
          end
        end
        ism_pkg::S_STOP_END: begin
          state_r <= ism_pkg::S_IDLE;
        end
        ism_pkg::S_RSTART: begin
          if (scl_rise) state_r <= ism_pkg::S_START;
        end
        default: state_r <= ism_pkg::S_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_stop_sent;
    state_r == ism_pkg::S_STOP_RISE && scl_rise ##1 stop_done && !acc.wr_ctrl;
  endsequence

  a_tx_write_clear: assert property (acc.wr_data |=> !tx_empty_r)
    else $error("transmit-empty not cleared by data write");
  a_tx_load_empty: assert property (load && !acc.wr_data |=> tx_empty_r)
    else $error("transmit-empty not set after load");
  a_tx_irq_raise: assert property (ev[ism_pkg::IRQ_TX_BIT] |=> irq_stat[ism_pkg::IRQ_TX_BIT])
    else $error("transmit interrupt not raised");
  a_dma_gated: assert property (!ctl_r.tx_irq_enable |=> !tx_dma_req_o)
    else $error("dma request without transmit enable");
  a_rx_full_set: assert property (rx_done && ctl_r.enable |=> rx_full_r ##1 irq_stat[ism_pkg::IRQ_RX_BIT])
    else $error("receive-full or its interrupt missing");
  a_rx_read_clear: assert property (acc.rd_data && !dbg_access_i && !rx_done |=> !rx_full_r)
    else $error("receive-full not cleared by read");
  a_rx_dbg_keep: assert property (acc.rd_data && dbg_access_i && rx_full_r |=> rx_full_r)
    else $error("debugger read cleared receive-full");
  a_ack_disable: assert property (!ctl_r.enable |=> !ackf_r)
    else $error("acknowledge flag kept while disabled");
  a_ack_update: assert property (ack_done && ctl_r.enable |=> ackf_r == $past(ack_val))
    else $error("acknowledge flag wrong after ack cycle");
  a_ack_keep: assert property ((start_load || acc.rd_stat) && ctl_r.enable && !ack_done |=> $stable(ackf_r))
    else $error("acknowledge flag changed by start or status read");
  a_stall_ack: assert property (state_r == ism_pkg::S_STALL && ctl_r.enable |=> $stable(ackf_r))
    else $error("acknowledge flag changed during stall");
  a_stall_release: assert property ((state_r == ism_pkg::S_STALL && acc.wr_data && ctl_r.enable) ##1 ctl_r.enable
    |=> state_r == ism_pkg::S_ACK)
    else $error("stall not released after data write");
  a_ten_detect: assert property (start_load |=> ten_r == $past(ten_hit))
    else $error("ten-bit flag wrong at start");
  a_ten_clear: assert property (ten_clr |=> !ten_r)
    else $error("ten-bit flag not cleared after first byte");
  a_rd_dir: assert property (start_load |=> rd_r == $past(dir_bit))
    else $error("read-direction flag wrong at start");
  a_addr_phase: assert property (start_load |=> st.addr_phase [*2])
    else $error("address phase not shown after start");
  a_data_phase: assert property (next_load && !next_addr |=> st.data_phase && !st.addr_phase)
    else $error("data phase not shown for data byte");
  a_nack_set: assert property (nack_ev |=> nack_r ##1 irq_stat[ism_pkg::IRQ_NACK_BIT])
    else $error("not-acknowledge flag or interrupt missing");
  a_nack_hold: assert property (nack_r && !acc.wr_ctrl && !stop_done |=> nack_r)
    else $error("not-acknowledge flag cleared without start or stop");
  a_stop_clear: assert property (s_stop_sent |=> !ctl_r.stop && !nack_r)
    else $error("stop or not-acknowledge kept after stop");
  a_start_sticky: assert property (ctl_r.start && !start_load && en_nxt |=> ctl_r.start)
    else $error("start request lost");
endmodule

// ==== verif/ism_slave_model.sv ====
// Purpose: Behavioural I2C slave that acknowledges and returns one byte per read.
// Assumes: Both bus lines have pull-ups; the model only ever pulls SDA low.
// Notes: The first byte after a start sets the direction.
module ism_slave_model (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic ack_en_i,
  input wire logic [7:0] tx_byte_i,
  output logic sda_pull_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = -1;
  logic rd_mode = 1'b0;
  logic first = 1'b0;
  logic [7:0] sh = 8'h00;
  initial sda_pull_o = 1'b0;
  // A start restarts the byte; a stop parks the model.
  always @(negedge sda_i) if (scl_i) begin
    cnt = 0;
    first = 1'b1;
    rd_mode = 1'b0;
  end
  always @(posedge sda_i) if (scl_i) cnt = -1;
  always @(posedge scl_i) begin
    if (cnt >= 0 && cnt < 8) begin
      sh = {sh[6:0], sda_i};
      cnt = cnt + 1;
    end else if (cnt == 8) begin
      cnt = (rd_mode && sda_i) ? -1 : 9;
    end
  end
  // Bits change only while SCL is low.
  always @(negedge scl_i) begin
    if (cnt == 8) begin
      sda_pull_o = rd_mode ? 1'b0 : ack_en_i;
      if (first) rd_mode = sh[0];
      first = 1'b0;
    end else if (cnt == 9) begin
      cnt = 0;
      sda_pull_o = rd_mode & ~tx_byte_i[7];
    end else if (cnt >= 1 && cnt <= 7 && rd_mode) begin
      sda_pull_o = ~tx_byte_i[7 - cnt];
    end else if (cnt < 0) begin
      sda_pull_o = 1'b0;
    end
  end
endmodule

// ==== verif/i2c_master_status_flags_tb.sv ====
// Purpose: Self-checking bench of the I2C master status flags.
// Assumes: SCL has a 400 ns period and waits while the engine holds it low; both lines have pull-ups.
// Notes: Flags are watched by polling the status register over the bus.
module i2c_master_status_flags_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic dbg = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic scl_oe;
  logic sda_oe;
  logic irq;
  logic dma;
  logic pull;
  logic ack_en = 1'b1;
  logic scl_gen = 1'b1;
  logic [7:0] rx_byte = 8'h00;
  logic [7:0] q;
  int error_cnt = 0;
  int compares = 0;
  wire scl = scl_gen & ~scl_oe;
  wire sda = ~sda_oe & ~pull;
  always #25 clk_i = ~clk_i;
  always begin
    #200 scl_gen = 1'b0;
    #200 wait (scl_oe !== 1'b1);
    scl_gen = 1'b1;
  end
  ism_i2c_status dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .dbg_access_i(dbg),
    .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .irq_o(irq),
    .tx_dma_req_o(dma));
  ism_slave_model slave_u (.scl_i(scl), .sda_i(sda), .ack_en_i(ack_en), .tx_byte_i(rx_byte), .sda_pull_o(pull));
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic hang(input string what);
    chk(what, 8'h00, 8'h01);
    tally_and_finish();
  endtask
  task automatic wb(input logic w, input logic [13:0] idx, input logic [7:0] d, input logic dg,
    output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    dbg <= dg;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    sel <= 4'h1;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 64);
    if (n >= 64) hang("bus answer");
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    dbg <= 1'b0;
  endtask
  task automatic rd(input logic [13:0] idx, output logic [7:0] r);
    wb(1'b0, idx, 8'h00, 1'b0, r);
  endtask
  task automatic wr(input logic [13:0] idx, input logic [7:0] d);
    logic [7:0] r;
    wb(1'b1, idx, d, 1'b0, r);
  endtask
  task automatic stat(input logic [7:0] m, input logic [7:0] v, input string what);
    rd(ism_pkg::IDX_STATUS, q);
    chk(what, q & m, v);
  endtask
  task automatic poll(input logic [13:0] idx, input logic [7:0] m, input logic [7:0] v);
    int n;
    n = 0;
    do begin
      rd(idx, q);
      n++;
    end while ((q & m) !== v && n < 600);
    if (n >= 600) hang("flag poll");
    chk("flag poll", q & m, v);
  endtask
  task automatic wait_held();
    int n;
    n = 0;
    while (scl_oe !== 1'b1 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 4000) hang("clock stretch");
  endtask
  initial begin
    void'($urandom(90815));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    stat(8'hff, 8'h80, "reset status");
    wr(ism_pkg::IDX_STATUS, 8'h7f);
    stat(8'hff, 8'h80, "status write");
    rd(14'h0010, q);
    chk("unmapped read", q, 8'h00);
    wr(ism_pkg::IDX_CTRL, 8'h88);
    repeat (4) @(posedge clk_i);
    chk("dma request", {7'h0, dma}, 8'h01);
    chk("masked irq", {7'h0, irq}, 8'h00);
    wr(ism_pkg::IDX_IRQ_MASK, 8'h07);
    repeat (4) @(posedge clk_i);
    chk("tx irq", {7'h0, irq}, 8'h01);
    wr(ism_pkg::IDX_CTRL, 8'h80);
    wr(ism_pkg::IDX_IRQ_STAT, 8'h07);
    rd(ism_pkg::IDX_IRQ_STAT, q);
    chk("irq cleared", q, 8'h00);
    chk("dma gated", {7'h0, dma}, 8'h00);
    chk("irq gated", {7'h0, irq}, 8'h00);
    wr(ism_pkg::IDX_DATA, {7'($urandom_range(119, 0)), 1'b0});
    stat(8'h80, 8'h00, "tx empty");
    wr(ism_pkg::IDX_CTRL, 8'hc0);
    poll(ism_pkg::IDX_STATUS, 8'h0c, 8'h04);
    wait_held();
    stat(8'h20, 8'h00, "ack before data");
    wr(ism_pkg::IDX_DATA, 8'($urandom));
    poll(ism_pkg::IDX_STATUS, 8'h22, 8'h22);
    wait_held();
    wr(ism_pkg::IDX_CTRL, 8'ha0);
    poll(ism_pkg::IDX_CTRL, 8'h20, 8'h00);
    stat(8'h27, 8'h20, "ack kept");
    wr(ism_pkg::IDX_CTRL, 8'h00);
    stat(8'h20, 8'h00, "ack disabled");
    ack_en <= 1'b0;
    wr(ism_pkg::IDX_CTRL, 8'hc0);
    wr(ism_pkg::IDX_CTRL, 8'h80);
    rd(ism_pkg::IDX_CTRL, q);
    chk("start kept", q & 8'h40, 8'h40);
    wr(ism_pkg::IDX_DATA, {ism_pkg::TEN_BIT_PREFIX, 2'($urandom), 1'b0});
    poll(ism_pkg::IDX_STATUS, 8'h10, 8'h10);
    wait_held();
    wr(ism_pkg::IDX_DATA, 8'($urandom));
    poll(ism_pkg::IDX_STATUS, 8'h21, 8'h01);
    wait_held();
    wr(ism_pkg::IDX_IRQ_STAT, 8'h04);
    stat(8'h01, 8'h01, "nack kept");
    chk("nack irq", {7'h0, irq}, 8'h01);
    wr(ism_pkg::IDX_CTRL, 8'ha0);
    poll(ism_pkg::IDX_STATUS, 8'h11, 8'h00);
    ack_en <= 1'b1;
    rx_byte <= 8'($urandom);
    wr(ism_pkg::IDX_DATA, {7'($urandom_range(119, 0)), 1'b1});
    wr(ism_pkg::IDX_CTRL, 8'hc4);
    poll(ism_pkg::IDX_STATUS, 8'h0c, 8'h0c);
    poll(ism_pkg::IDX_STATUS, 8'h41, 8'h41);
    wb(1'b0, ism_pkg::IDX_DATA, 8'h00, 1'b1, q);
    chk("debug read", q, rx_byte);
    stat(8'h40, 8'h40, "full after debug read");
    chk("rx irq", {7'h0, irq}, 8'h01);
    rd(ism_pkg::IDX_DATA, q);
    chk("data read", q, rx_byte);
    stat(8'h40, 8'h00, "full after read");
    wr(ism_pkg::IDX_CTRL, 8'ha0);
    poll(ism_pkg::IDX_STATUS, 8'h01, 8'h00);
    tally_and_finish();
  end
endmodule
